//--- hdl/dac_four_channel_control.sv
// Purpose: register file and switch drive of a four-channel 8-bit ladder converter
// Assumes: classic Wishbone master on clk; standby level comes from logic on clk
// Notes: ack is registered; a write takes effect on the edge where ack is high
module dac_four_channel_control
    import dac_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,

    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,

    // power mode
    input wire logic standby,

    // ladder switches and pin enables
    output ladder_bus_t ladder
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    localparam dac_state_t STATE_RST = '{
        code: {CH_COUNT{CODE_RST}},
        control: CONTROL_RST_FIELDS,
        ack: 1'b0,
        rdata: CODE_RST
    };

    dac_state_t state;
    dac_state_t next_state;

    // ------------------------------------------------------------
    // bus request decode
    // ------------------------------------------------------------
    logic req;
    logic [IDX_W-1:0] word_idx;
    logic hit_code;
    logic [1:0] hit_ch;
    logic hit_control;
    logic hit_status;
    logic write_now;
    logic code_lane;

    // request and word index from the byte address
    assign req = wb_cyc_i & wb_stb_i;
    assign word_idx = wb_adr_i[31:2];
    assign code_lane = wb_sel_i[SEL_CODE_LANE];

    // address match for each register
    always_comb begin
        hit_code = 1'b0;
        hit_ch = 2'd0;
        hit_control = 1'b0;
        hit_status = 1'b0;
        case (word_idx)
            IDX_CH0_CODE: begin
                hit_code = 1'b1;
                hit_ch = 2'd0;
            end
            IDX_CH1_CODE: begin
                hit_code = 1'b1;
                hit_ch = 2'd1;
            end
            IDX_CH2_CODE: begin
                hit_code = 1'b1;
                hit_ch = 2'd2;
            end
            IDX_CH3_CODE: begin
                hit_code = 1'b1;
                hit_ch = 2'd3;
            end
            IDX_CONTROL: begin
                hit_control = 1'b1;
            end
            IDX_STATUS: begin
                hit_status = 1'b1;
            end
            default: begin
                hit_code = 1'b0;
            end
        endcase
    end

    // write lands on the edge that also shows ack to the master
    assign write_now = req & state.ack & wb_we_i & code_lane;

    // ------------------------------------------------------------
    // read views
    // ------------------------------------------------------------
    logic [7:0] control_view;
    logic [7:0] status_view;
    logic [CH_COUNT-1:0] channel_active;

    // a channel converts only with global and own enable set
    assign channel_active = {CH_COUNT{state.control.conversion_enable_all}}
                            & state.control.output_enable;

    // fixed upper bits always read as one
    always_comb begin
        control_view = CONTROL_FIXED;
        control_view[CTRL_EN_BIT] = state.control.conversion_enable_all;
        control_view[CTRL_OE_LSB +: CH_COUNT] = state.control.output_enable;
    end

    // standby flag and per-channel activity
    always_comb begin
        status_view = 8'h00;
        status_view[STAT_STANDBY_BIT] = standby;
        status_view[STAT_ACTIVE_LSB +: CH_COUNT] = channel_active;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;

        // ack rises one cycle after the request and falls after one cycle
        next_state.ack = req & ~state.ack;

        // capture read data together with ack; unmapped reads give zero
        if (req && !state.ack) begin
            if (hit_code) begin
                next_state.rdata = state.code[hit_ch];
            end else if (hit_control) begin
                next_state.rdata = control_view;
            end else if (hit_status) begin
                next_state.rdata = status_view;
            end else begin
                next_state.rdata = CODE_RST;
            end
        end

        // code writes touch only the addressed channel
        if (write_now && hit_code) begin
            next_state.code[hit_ch] = wb_dat_i[7:0];
        end

        // control writes skip the fixed upper bits
        if (write_now && hit_control) begin
            next_state.control.conversion_enable_all = wb_dat_i[CTRL_EN_BIT];
            next_state.control.output_enable = wb_dat_i[CTRL_OE_LSB +: CH_COUNT];
        end

        // standby returns control to its reset value, codes are kept
        if (standby) begin
            next_state.control = CONTROL_RST_FIELDS;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------

    // one register for all state; ce low freezes it, but rst loads the reset value whatever ce is
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= STATE_RST;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // bus outputs
    // ------------------------------------------------------------

    // read data sits in the low byte, upper bytes are zero
    assign wb_dat_o = {24'h000000, state.rdata};
    assign wb_ack_o = state.ack;

    // ------------------------------------------------------------
    // per-channel ladder drive
    // ------------------------------------------------------------

    // independent path per channel, fed by its own code, its own output enable and the shared global enable
    for (genvar ch = 0; ch < CH_COUNT; ch++) begin : g_channel
        ladder_channel_drive u_drive (
            .code(state.code[ch]),
            .conversion_enable_all(state.control.conversion_enable_all),
            .output_enable(state.control.output_enable[ch]),
            .switches(ladder.switches[ch]),
            .analog_out_oe(ladder.analog_out_oe[ch])
        );
    end

endmodule // dac_four_channel_control

//--- hdl/dac_pkg.sv
// Purpose: shared constants and types of the four-channel ladder converter control
// Assumes: classic Wishbone slave, 32-bit data, one aligned word per register
// Notes: register indices are the printed offsets; byte address is four times the index
package dac_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int CH_COUNT = 4;
    localparam int CODE_W = 8;
    localparam int IDX_W = 30;

    // ------------------------------------------------------------
    // register indices (byte address = index * 4)
    // ------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_CH0_CODE = 30'h0000ffc8;
    localparam logic [IDX_W-1:0] IDX_CH1_CODE = 30'h0000ffc9;
    localparam logic [IDX_W-1:0] IDX_CH2_CODE = 30'h0000ffca;
    localparam logic [IDX_W-1:0] IDX_CH3_CODE = 30'h0000ffcb;
    localparam logic [IDX_W-1:0] IDX_CONTROL = 30'h0000ffcc;
    localparam logic [IDX_W-1:0] IDX_STATUS = 30'h0000ffcd;

    // ------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] CODE_RST = 8'h00;
    localparam logic [7:0] CONTROL_RST = 8'he0;
    localparam logic [7:0] CONTROL_FIXED = 8'he0;
    localparam int CTRL_EN_BIT = 4;
    localparam int CTRL_OE_LSB = 0;
    localparam int STAT_STANDBY_BIT = 4;
    localparam int STAT_ACTIVE_LSB = 0;
    localparam int SEL_CODE_LANE = 0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef logic [CODE_W-1:0] code_t;
    typedef code_t [CH_COUNT-1:0] code_array_t;

    typedef struct packed {
        logic conversion_enable_all;
        logic [CH_COUNT-1:0] output_enable;
    } control_t;

    typedef struct packed {
        code_array_t code;
        control_t control;
        logic ack;
        code_t rdata;
    } dac_state_t;

    typedef struct packed {
        code_array_t switches;
        logic [CH_COUNT-1:0] analog_out_oe;
    } ladder_bus_t;

    localparam control_t CONTROL_RST_FIELDS = '{conversion_enable_all: 1'b0, output_enable: 4'h0};

endpackage

//--- hdl/ladder_channel_drive.sv
// Purpose: drive one channel's eight ladder switches and its pin enable
// Assumes: code and enables come from flip-flops on the same clock
// Notes: purely combinational so a register write reaches the switches at once
module ladder_channel_drive
    import dac_pkg::*;
(
    // channel settings
    input wire code_t code,
    input wire logic conversion_enable_all,
    input wire logic output_enable,
    // ladder side
    output code_t switches,
    output logic analog_out_oe
);

    // ------------------------------------------------------------
    // switch drive
    // ------------------------------------------------------------

    // one switch per code bit; halted conversion shows the zero code
    always_comb begin
        if (conversion_enable_all) begin
            switches = code;
        end else begin
            switches = CODE_RST;
        end
    end

    // cleared enable leaves the pin floating
    assign analog_out_oe = output_enable;

endmodule // ladder_channel_drive

//--- tb/dac_asserts.sv
// Purpose: bus and ladder checks at the top ports
// Assumes: ce high in normal runs
// Notes: register state is seen through the ladder
module dac_asserts
    import dac_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // power and ladder
    input wire logic standby,
    input wire ladder_bus_t ladder
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // accepted accesses
    wire logic wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] && ce;
    wire logic rd = wb_ack_o && !wb_we_i;
    wire logic [29:0] idx = wb_adr_i[31:2];

    chk_ack_timing: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o)
        else $error("ack late");
    chk_ack_pulse: assert property (wb_ack_o && ce |=> !wb_ack_o)
        else $error("ack too long");
    chk_read_upper: assert property (rd |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper read bits set");
    chk_ctrl_fixed: assert property (rd && idx == IDX_CONTROL |-> wb_dat_o[7:5] == 3'h7)
        else $error("fixed bits not one");
    chk_ctrl_write: assert property (wr && !standby && idx == IDX_CONTROL |=>
        ladder.analog_out_oe == $past(wb_dat_i[3:0]) && ($past(wb_dat_i[4]) || ladder.switches == '0))
        else $error("control write not applied");
    chk_code_write: assert property (wr && !standby && idx == IDX_CH2_CODE |=>
        (ladder.switches[2] == $past(wb_dat_i[7:0]) || ladder.switches[2] == 8'h00) && $stable(ladder.switches[1]))
        else $error("code write wrong");
    chk_standby_clear: assert property (standby && ce |=> ladder == '0)
        else $error("standby left outputs on");
    chk_quiet_hold: assert property (!$stable(ladder) |-> $past(wr) || $past(standby))
        else $error("ladder moved by itself");
    chk_reset_clear: assert property (disable iff (1'b0) rst && ce |=> ladder == '0)
        else $error("reset left outputs on");
    // main scenarios
    cover property (wr && idx == IDX_CONTROL);
    cover property (standby);
    cover property (rd && idx == IDX_CH0_CODE);
endmodule // dac_asserts

bind dac_four_channel_control dac_asserts chk (.clk(clk), .rst(rst), .ce(ce), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .standby(standby), .ladder(ladder));

//--- tb/ladder_pins.sv
// Purpose: four ladder outputs seen from the pins
// Assumes: bit b weighs 2**b reference steps
// Notes: a floating pin shows the inverse of its last level
module ladder_pins
    import dac_pkg::*;
(
    // clock
    input wire logic clk,
    // ladder side
    input wire ladder_bus_t ladder,
    // pin levels in steps
    output code_array_t level
);
    timeunit 1ns;
    timeprecision 1ps;
    code_array_t sum;
    code_array_t last;
    // each channel sums its own set switches
    always_comb begin
        for (int c = 0; c < CH_COUNT; c++) begin
            sum[c] = 8'h00;
            for (int b = 0; b < CODE_W; b++) begin
                sum[c] = sum[c] + (ladder.switches[c][b] ? 8'(1 << b) : 8'h00);
            end
            level[c] = ladder.analog_out_oe[c] ? sum[c] : ~last[c];
        end
    end
    // remember the last driven level
    always_ff @(posedge clk) begin
        for (int c = 0; c < CH_COUNT; c++) begin
            if (ladder.analog_out_oe[c]) last[c] <= sum[c];
        end
    end
endmodule // ladder_pins

//--- tb/tb.sv
// Purpose: register and ladder tests of the converter control
// Assumes: one access at a time, low byte lane
// Notes: cyc and stb share one request signal
module tb
    import dac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req = 1'b0;
    logic we = 1'b0;
    logic sby = 1'b0;
    logic ce = 1'b1;
    logic ack;
    logic [31:0] adr = 32'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    ladder_bus_t ladder;
    code_array_t level;
    code_array_t cv = {8'h8a, 8'h3c, 8'h01, 8'hff};
    int failures = 0;
    int checked = 0;

    // clock
    initial begin
        forever #2 clk = ~clk;
    end

    dac_four_channel_control dut (.clk(clk), .rst(rst), .ce(ce), .wb_cyc_i(req), .wb_stb_i(req),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .standby(sby), .ladder(ladder));
    ladder_pins pins (.clk(clk), .ladder(ladder), .level(level));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one classic cycle, read data compared at the ack edge
    task automatic bus(input logic w, input logic [29:0] idx, input logic [7:0] d, input logic [31:0] exp);
        int n;
        n = 0;
        @(posedge clk);
        req <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {24'h000000, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            finish_test();
        end
        if (!w) check(rdat, exp);
        req <= 1'b0;
    endtask

    // pin enables, switches and driven levels
    task automatic out(input logic [3:0] oe, input code_array_t sw);
        @(negedge clk);
        check(32'(ladder.analog_out_oe), 32'(oe));
        check(32'(ladder.switches), 32'(sw));
        for (int c = 0; c < CH_COUNT; c++) begin
            if (oe[c]) check(32'(level[c]), 32'(sw[c]));
        end
    endtask

    task automatic finish_test();
        if (failures == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        finish_test();
    end

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int c = 0; c < 5; c++) bus(0, IDX_CH0_CODE + 30'(c), 0, c == 4 ? 32'he0 : 32'h0);
        bus(0, IDX_STATUS + 30'h1, 0, 32'h0);
        for (int c = 0; c < 4; c++) bus(1, IDX_CH0_CODE + 30'(c), cv[c], 0);
        for (int c = 0; c < 4; c++) bus(0, IDX_CH0_CODE + 30'(c), 0, 32'(cv[c]));
        out(4'h0, '0);
        bus(1, IDX_CONTROL, 8'h15, 0);
        bus(0, IDX_CONTROL, 0, 32'(CONTROL_FIXED | 8'h15));
        bus(0, IDX_STATUS, 0, 32'h05);
        out(4'h5, cv);
        bus(1, IDX_CONTROL, 8'h0f, 0);
        out(4'hf, '0);
        bus(1, IDX_CONTROL, 8'h1f, 0);
        bus(1, IDX_CH1_CODE, 8'h5a, 0);
        cv[1] = 8'h5a;
        out(4'hf, cv);
        // frozen clock enable ignores a standby pulse
        ce <= 1'b0;
        @(posedge clk);
        sby <= 1'b1;
        @(posedge clk);
        sby <= 1'b0;
        ce <= 1'b1;
        out(4'hf, cv);
        @(posedge clk);
        sby <= 1'b1;
        @(posedge clk);
        sby <= 1'b0;
        out(4'h0, '0);
        bus(0, IDX_CONTROL, 0, 32'he0);
        bus(0, IDX_CH1_CODE, 0, 32'h5a);
        finish_test();
    end
endmodule // tb
